// ---- core/fweg_guard.sv ----
`timescale 1ns/1ps
// Function
// - byte writes only clear bits; page erase sets the whole page to all ones.
// - writes and erases are self-timed and the cpu stays stalled throughout.
// - with write enable set, external moves go to flash instead of data ram.
// - write enable stays set until software writes it back to zero.
// - flash modify with supply monitor or its reset source off forces error reset.
// - key register takes first code then second code, any delay between.
// - wrong or out-of-order key code disables flash modify until reset.
// - flash modify attempted before a full key pair also disables until reset.
// - every completed software write or erase returns the key to locked.
// - an erase move to any address in a page erases that whole page.
// - erase needs both enables; byte write needs write enable without erase enable.
// - locked page count from page 0 equals ones complement of the lock byte.
// - any locked page locks the lock byte page too; else it is unlocked.
// - unlocked-page code touching a locked page gets error reset; locked code may.
// - firmware changing lock byte bits or erasing its page gets error reset.
// - firmware touching the reserved area gets error reset; debug is refused there.
// - forbidden debug port operations are silently ignored, never resetting.
// - debug full erase clears every page including lock page and scratchpad.
// - a new lock byte takes effect only after the next device reset.
// - after an error reset the flash error flag reads one.
// - scratchpad counts as locked when all other pages are locked.
// - power-on reset enables supply monitor and its reset source.
module fweg_guard import fweg_pkg::*; #(
	parameter int unsigned ERASE_N = ERASE_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        power_on,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	input  wire logic        xw_req,
	input  wire logic [15:0] xw_addr,
	input  wire logic [7:0]  xw_data,
	output logic             xw_to_flash,
	input  wire logic [15:0] exec_addr,
	input  wire logic        cr_req,
	input  wire logic [15:0] cr_addr,
	output logic             cr_valid,
	output logic      [7:0]  cr_data,
	output logic             cpu_stall,
	input  wire logic        dbg_req,
	input  wire fweg_op_e    dbg_op,
	input  wire logic [15:0] dbg_addr,
	input  wire logic [7:0]  dbg_wdata,
	output logic             dbg_ack,
	output logic             dbg_refused,
	output logic      [7:0]  dbg_rdata,
	output logic             flash_err_rst,
	output logic             supply_mon_en,
	output logic             supply_rst_en
);
	typedef enum logic [4:0] {
		ST_LOAD  = 5'h01,
		ST_LATCH = 5'h02,
		ST_IDLE  = 5'h04,
		ST_BUSY  = 5'h08,
		ST_ERR   = 5'h10
	} fweg_st_e;

	typedef struct packed {
		fweg_st_e  st;
		fweg_key_e key;
		logic      key_dead;
		logic [7:0] psc;
		logic      smon_en;
		logic      srst_en;
		logic      err_pend;
		logic      ferr;
		logic [7:0] lock;
		logic [7:0] pid;
		logic [7:0] sfr_rdata;
		logic      cr_valid;
		logic      dbg_pend;
		logic      dbg_ack;
		logic      dbg_refused;
	} fweg_guard_s;

	fweg_guard_s cur;
	fweg_guard_s next_state;
	fweg_arr_if  fa ();

	fweg_array #(
		.ERASE_N (ERASE_N)
	) u_array (
		.clk_sys (clk_sys),
		.srst    (srst),
		.fa      (fa.store)
	);

	// byte address to array index; scratchpad sits after user space
	function automatic logic [IDX_W-1:0] addr_idx(logic [15:0] a, logic scr);
		addr_idx = scr ? IDX_W'(USER_BYTES) + {5'h00, a[8:0]} : {1'b0, a[12:0]};
	endfunction

	function automatic logic is_reserved(logic [15:0] a, logic scr);
		is_reserved = !scr && (a >= 16'(USER_BYTES));
	endfunction

	// lock test against the latched byte
	function automatic logic page_locked(logic [15:0] a, logic scr, logic [7:0] lk);
		logic [7:0] n;
		n = ~lk;
		if (scr) begin
			page_locked = n >= {4'h0, LOCK_PAGE};
		end else if (is_reserved(a, 1'b0)) begin
			page_locked = 1'b0;
		end else if (a[12:9] == LOCK_PAGE) begin
			page_locked = n != 8'h00;
		end else begin
			page_locked = {4'h0, a[12:9]} < n;
		end
	endfunction

	// firmware access that must end in an error reset
	function automatic logic fw_bad(fweg_op_e op, logic [15:0] a, logic [7:0] d,
		logic scr, logic [15:0] ex, logic [7:0] lk);
		logic lk_page;
		lk_page = !scr && (a[15:9] == LOCK_ADDR[15:9]);
		fw_bad = is_reserved(a, scr)
			|| (page_locked(a, scr, lk) && !page_locked(ex, 1'b0, lk))
			|| (op == OP_ERASE && lk_page)
			|| (op == OP_WRITE && !scr && a == LOCK_ADDR && (d & lk) != lk);
	endfunction

	// debug access that is quietly refused
	function automatic logic dbg_bad(fweg_op_e op, logic [15:0] a, logic [7:0] d,
		logic [7:0] lk);
		if (op == OP_FULL) begin
			dbg_bad = 1'b0;
		end else begin
			dbg_bad = is_reserved(a, 1'b0) || page_locked(a, 1'b0, lk)
				|| (op == OP_WRITE && a == LOCK_ADDR && lk != ERASED && (d & lk) != lk);
		end
	endfunction

	// whole controller: reset, arbitration, checks, register file
	always_comb begin
		logic      pwe;
		logic      pee;
		logic      scr;
		logic [7:0] rv;
		fweg_op_e  xop;
		pwe = cur.psc[PSC_PWE_BIT];
		pee = cur.psc[PSC_PEE_BIT];
		scr = cur.psc[PSC_SCR_BIT];
		rv = 8'h00;
		xop = pee ? OP_ERASE : OP_WRITE;
		next_state = cur;
		next_state.cr_valid = 1'b0;
		next_state.dbg_ack = 1'b0;
		next_state.dbg_refused = 1'b0;
		fa.start = 1'b0;
		fa.kind = xop;
		fa.idx = addr_idx(xw_addr, scr);
		fa.wdata = xw_data;
		fa.rd_idx = addr_idx(cr_addr, scr);
		if (srst) begin
			// error cause survives the reset it requested
			next_state.st = ST_LOAD;
			next_state.key = KEY_LOCKED;
			next_state.key_dead = 1'b0;
			next_state.psc = PSC_RST;
			next_state.pid = PID_RST;
			next_state.sfr_rdata = 8'h00;
			next_state.dbg_pend = 1'b0;
			next_state.ferr = cur.err_pend && !power_on;
			next_state.err_pend = cur.err_pend && !power_on;
			if (power_on) begin
				next_state.smon_en = 1'b1;
				next_state.srst_en = 1'b1;
			end
		end else begin
			case (cur.st)
				ST_LOAD: begin
					fa.rd_idx = addr_idx(LOCK_ADDR, 1'b0);
					next_state.err_pend = 1'b0;
					next_state.st = ST_LATCH;
				end
				ST_LATCH: begin
					next_state.lock = fa.rd_data;
					next_state.st = ST_IDLE;
				end
				ST_IDLE: begin
					if (xw_req && pwe) begin
						if (!(cur.smon_en && cur.srst_en)) begin
							next_state.st = ST_ERR;
							next_state.err_pend = 1'b1;
						end else if (cur.key != KEY_OPEN || cur.key_dead) begin
							next_state.key_dead = 1'b1;
							next_state.key = KEY_LOCKED;
						end else if (fw_bad(xop, xw_addr, xw_data, scr, exec_addr,
							cur.lock)) begin
							next_state.st = ST_ERR;
							next_state.err_pend = 1'b1;
						end else begin
							fa.start = 1'b1;
							next_state.st = ST_BUSY;
						end
					end else if (cr_req) begin
						if (fw_bad(OP_READ, cr_addr, 8'h00, scr, exec_addr, cur.lock)) begin
							next_state.st = ST_ERR;
							next_state.err_pend = 1'b1;
						end else begin
							next_state.cr_valid = 1'b1;
						end
					end else if (dbg_req) begin
						fa.kind = dbg_op;
						fa.idx = addr_idx(dbg_addr, 1'b0);
						fa.wdata = dbg_wdata;
						fa.rd_idx = addr_idx(dbg_addr, 1'b0);
						if (dbg_bad(dbg_op, dbg_addr, dbg_wdata, cur.lock)) begin
							next_state.dbg_ack = 1'b1;
							next_state.dbg_refused = 1'b1;
						end else if (dbg_op == OP_READ) begin
							next_state.dbg_ack = 1'b1;
						end else begin
							fa.start = 1'b1;
							next_state.dbg_pend = 1'b1;
							next_state.st = ST_BUSY;
						end
					end
				end
				ST_BUSY: begin
					if (fa.done) begin
						next_state.st = ST_IDLE;
						next_state.dbg_pend = 1'b0;
						next_state.dbg_ack = cur.dbg_pend;
						if (!cur.dbg_pend) begin
							next_state.key = KEY_LOCKED;
						end
					end
				end
				ST_ERR: begin
					next_state.st = ST_ERR;
				end
				default: begin
					next_state.st = ST_LOAD;
				end
			endcase

			// register writes; the cpu is stalled while busy
			if (sfr_wr) begin
				case (sfr_addr)
					PSC_OFS: next_state.psc = sfr_wdata;
					KEY_OFS: begin
						if (!cur.key_dead) begin
							case (cur.key)
								KEY_LOCKED: begin
									if (sfr_wdata == KEY_FIRST) begin
										next_state.key = KEY_HALF;
									end else begin
										next_state.key_dead = 1'b1;
									end
								end
								KEY_HALF: begin
									if (sfr_wdata == KEY_SECOND) begin
										next_state.key = KEY_OPEN;
									end else begin
										next_state.key = KEY_LOCKED;
										next_state.key_dead = 1'b1;
									end
								end
								default: begin
									next_state.key = KEY_LOCKED;
									next_state.key_dead = 1'b1;
								end
							endcase
						end
					end
					RSRC_OFS: next_state.srst_en = sfr_wdata[RSRC_MON_BIT];
					SMON_OFS: next_state.smon_en = sfr_wdata[SMON_EN_BIT];
					PID_OFS: next_state.pid = sfr_wdata;
					default: next_state.psc = cur.psc;
				endcase
			end

			// register reads, unmapped offsets read zero
			if (sfr_rd) begin
				case (sfr_addr)
					PSC_OFS: rv = cur.psc;
					KEY_OFS: begin
						rv[KEY_HALF_BIT] = cur.key == KEY_HALF;
						rv[KEY_OPEN_BIT] = cur.key == KEY_OPEN;
						rv[KEY_DEAD_BIT] = cur.key_dead;
					end
					RSRC_OFS: begin
						rv[RSRC_MON_BIT] = cur.srst_en;
						rv[RSRC_FERR_BIT] = cur.ferr;
					end
					SMON_OFS: rv[SMON_EN_BIT] = cur.smon_en;
					PID_OFS: rv = cur.pid;
					default: rv = 8'h00;
				endcase
				next_state.sfr_rdata = rv;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		cur <= next_state;
	end

	// outputs; stall covers the lock fetch after reset too
	assign xw_to_flash = cur.psc[PSC_PWE_BIT];
	assign cpu_stall = cur.st != ST_IDLE;
	assign flash_err_rst = cur.st == ST_ERR;
	assign sfr_rdata = cur.sfr_rdata;
	assign cr_valid = cur.cr_valid;
	assign cr_data = fa.rd_data;
	assign dbg_ack = cur.dbg_ack;
	assign dbg_refused = cur.dbg_refused;
	assign dbg_rdata = fa.rd_data;
	assign supply_mon_en = cur.smon_en;
	assign supply_rst_en = cur.srst_en;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	route_follow_a: assert property (
		sfr_wr && sfr_addr == PSC_OFS |=> xw_to_flash == $past(sfr_wdata[PSC_PWE_BIT]))
		else $error("flash routing does not follow write enable");
	pwe_hold_a: assert property (
		xw_to_flash && !(sfr_wr && sfr_addr == PSC_OFS) |=> xw_to_flash)
		else $error("write enable dropped without a write");
	key_order_a: assert property (
		sfr_wr && sfr_addr == KEY_OFS && cur.key == KEY_LOCKED && sfr_wdata != KEY_FIRST
		|=> cur.key_dead [*2])
		else $error("bad first key code did not disable flash");
	no_key_a: assert property (
		cur.st == ST_IDLE && xw_req && xw_to_flash && cur.smon_en && cur.srst_en
		&& cur.key != KEY_OPEN |-> !fa.start ##1 cur.key_dead)
		else $error("modify without key was not blocked");
	relock_a: assert property (
		cur.st == ST_BUSY && fa.done && !cur.dbg_pend |=> cur.key == KEY_LOCKED)
		else $error("key did not relock after operation");
	supply_err_a: assert property (
		cur.st == ST_IDLE && xw_req && xw_to_flash && !(cur.smon_en && cur.srst_en)
		|=> flash_err_rst && !fa.busy)
		else $error("modify with supply monitor off did not reset");
	stall_busy_a: assert property (
		fa.busy |-> cpu_stall)
		else $error("cpu ran while flash busy");
	err_no_mod_a: assert property (
		flash_err_rst |-> !fa.start && !$rose(fa.busy))
		else $error("array started during error reset");
	dbg_quiet_a: assert property (
		cur.st == ST_IDLE && dbg_req && !xw_req && !cr_req |=> !flash_err_rst)
		else $error("debug access caused an error reset");
	erase_kind_a: assert property (
		fa.start && !dbg_req |-> fa.kind == (cur.psc[PSC_PEE_BIT] ? OP_ERASE : OP_WRITE))
		else $error("operation kind does not match enables");
	mon_por_a: assert property (
		$fell(srst) && $past(power_on) |-> supply_mon_en && supply_rst_en)
		else $error("supply monitor not enabled after power-on");
	ferr_flag_a: assert property (
		$fell(srst) && $past(cur.err_pend) && !$past(power_on) |-> cur.ferr)
		else $error("error flag clear after error reset");
	lock_hold_a: assert property (
		cur.st == ST_IDLE && $past(cur.st) == ST_IDLE |-> $stable(cur.lock))
		else $error("lock range changed without reset");

	erase_seen_c: cover property (fa.start && fa.kind == OP_ERASE);
	full_seen_c: cover property (fa.start && fa.kind == OP_FULL);
	err_seen_c: cover property ($rose(flash_err_rst));
	refuse_seen_c: cover property (dbg_refused);
endmodule

// ---- core/fweg_pkg.sv ----
package fweg_pkg;
	// clock and operation timing
	localparam int unsigned CLK_MHZ    = 200;
	localparam int unsigned T_WRITE_NS = 20000;
	localparam int unsigned WRITE_CYC  = (T_WRITE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_ERASE_US = 20000;
	localparam int unsigned ERASE_CYC  = T_ERASE_US * CLK_MHZ;
	localparam int unsigned CNT_W      = 23;

	// array geometry: user pages, then one scratchpad page
	localparam int unsigned PAGE_SHIFT = 9;
	localparam int unsigned USER_BYTES = 8192;
	localparam int unsigned DEPTH      = USER_BYTES + 512;
	localparam int unsigned IDX_W      = 14;
	localparam logic [15:0] LOCK_ADDR  = 16'h1fff;
	localparam logic [3:0]  LOCK_PAGE  = 4'hf;
	localparam logic [7:0]  ERASED     = 8'hff;

	// key codes
	localparam logic [7:0] KEY_FIRST  = 8'ha5;
	localparam logic [7:0] KEY_SECOND = 8'hf1;

	// register offsets
	localparam logic [7:0] PSC_OFS  = 8'h8f;
	localparam logic [7:0] KEY_OFS  = 8'hb7;
	localparam logic [7:0] PID_OFS  = 8'he3;
	localparam logic [7:0] RSRC_OFS = 8'hef;
	localparam logic [7:0] SMON_OFS = 8'hff;

	// field positions
	localparam int unsigned PSC_PWE_BIT   = 0;
	localparam int unsigned PSC_PEE_BIT   = 1;
	localparam int unsigned PSC_SCR_BIT   = 2;
	localparam int unsigned RSRC_MON_BIT  = 1;
	localparam int unsigned RSRC_FERR_BIT = 6;
	localparam int unsigned SMON_EN_BIT   = 7;
	localparam int unsigned KEY_HALF_BIT  = 0;
	localparam int unsigned KEY_OPEN_BIT  = 1;
	localparam int unsigned KEY_DEAD_BIT  = 2;

	// reset values; the identifier value is arbitrary
	localparam logic [7:0] PSC_RST = 8'h00;
	localparam logic [7:0] PID_RST = 8'h3c;

	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_ERASE = 2'h1,
		OP_FULL  = 2'h2,
		OP_READ  = 2'h3
	} fweg_op_e;

	typedef enum logic [2:0] {
		KEY_LOCKED = 3'h1,
		KEY_HALF   = 3'h2,
		KEY_OPEN   = 3'h4
	} fweg_key_e;
endpackage

// ---- core/fweg_arr_if.sv ----
`timescale 1ns/1ps
interface fweg_arr_if import fweg_pkg::*; ();
	logic             start;
	fweg_op_e         kind;
	logic [IDX_W-1:0] idx;
	logic [7:0]       wdata;
	logic [IDX_W-1:0] rd_idx;
	logic [7:0]       rd_data;
	logic             busy;
	logic             done;

	modport ctrl  (output start, kind, idx, wdata, rd_idx, input rd_data, busy, done);
	modport store (input start, kind, idx, wdata, rd_idx, output rd_data, busy, done);
endinterface

// ---- core/fweg_array.sv ----
`timescale 1ns/1ps
module fweg_array import fweg_pkg::*; #(
	parameter int unsigned ERASE_N = ERASE_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	fweg_arr_if.store fa
);
	typedef struct packed {
		logic             busy;
		fweg_op_e         kind;
		logic [CNT_W-1:0] cnt;
		logic [IDX_W-1:0] idx;
		logic [7:0]       wdata;
		logic [IDX_W-1:0] ptr;
		logic [IDX_W-1:0] last;
		logic             done;
		logic [7:0]       rd_data;
	} fweg_arr_s;

	fweg_arr_s        cur;
	fweg_arr_s        next_state;
	// a fresh part comes out erased; one writer process keeps a single driver
	logic [7:0]       mem [0:DEPTH-1] = '{default: ERASED};
	logic             mem_we;
	logic [IDX_W-1:0] mem_wi;
	logic [7:0]       mem_wd;

	// self-timed: wait, then apply; erase sweeps one byte a cycle
	always_comb begin
		next_state = cur;
		next_state.done = 1'b0;
		next_state.rd_data = mem[fa.rd_idx];
		mem_we = 1'b0;
		mem_wi = cur.ptr;
		mem_wd = ERASED;
		if (srst) begin
			next_state = '0;
		end else if (!cur.busy) begin
			if (fa.start) begin
				next_state.busy = 1'b1;
				next_state.kind = fa.kind;
				next_state.idx = fa.idx;
				next_state.wdata = fa.wdata;
				next_state.cnt = (fa.kind == OP_WRITE) ? CNT_W'(WRITE_CYC - 1) :
					CNT_W'(ERASE_N - 1);
				case (fa.kind)
					OP_ERASE: begin
						next_state.ptr = {fa.idx[IDX_W-1:PAGE_SHIFT], 9'h000};
						next_state.last = {fa.idx[IDX_W-1:PAGE_SHIFT], 9'h1ff};
					end
					OP_FULL: begin
						next_state.ptr = '0;
						next_state.last = IDX_W'(DEPTH - 1);
					end
					default: begin
						next_state.ptr = fa.idx;
						next_state.last = fa.idx;
					end
				endcase
			end
		end else if (cur.cnt != '0) begin
			next_state.cnt = cur.cnt - 1'b1;
		end else if (cur.kind == OP_WRITE) begin
			mem_we = 1'b1;
			mem_wi = cur.idx;
			mem_wd = mem[cur.idx] & cur.wdata;
			next_state.busy = 1'b0;
			next_state.done = 1'b1;
		end else begin
			mem_we = 1'b1;
			next_state.ptr = cur.ptr + 1'b1;
			if (cur.ptr == cur.last) begin
				next_state.busy = 1'b0;
				next_state.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		cur <= next_state;
		if (mem_we) begin
			mem[mem_wi] <= mem_wd;
		end
	end

	assign fa.busy = cur.busy;
	assign fa.done = cur.done;
	assign fa.rd_data = cur.rd_data;

	write_clears_a: assert property (@(posedge clk_sys) disable iff (srst)
		mem_we && cur.kind == OP_WRITE
		|=> mem[$past(cur.idx)] == ($past(mem[cur.idx]) & $past(cur.wdata)))
		else $error("byte write left a bit at one that data cleared");
	erase_ones_a: assert property (@(posedge clk_sys) disable iff (srst)
		mem_we && cur.kind != OP_WRITE |=> mem[$past(mem_wi)] == ERASED)
		else $error("erased byte does not read all ones");
endmodule

// ---- tb/fweg_cpu_model.sv ----
`timescale 1ns/1ps
// cpu core and debug port side: one request per task, changed only after an edge
module fweg_cpu_model import fweg_pkg::*; (
	input  wire logic        clk_sys,
	output logic             sfr_wr,
	output logic             sfr_rd,
	output logic      [7:0]  sfr_addr,
	output logic      [7:0]  sfr_wdata,
	output logic             xw_req,
	output logic      [15:0] xw_addr,
	output logic      [7:0]  xw_data,
	output logic             cr_req,
	output logic      [15:0] cr_addr,
	output logic             dbg_req,
	output fweg_op_e         dbg_op,
	output logic      [15:0] dbg_addr,
	output logic      [7:0]  dbg_wdata,
	input  wire logic        cpu_stall,
	input  wire logic        cr_valid,
	input  wire logic [7:0]  cr_data,
	input  wire logic        dbg_ack,
	input  wire logic        dbg_refused,
	input  wire logic [7:0]  dbg_rdata
);
	// idle bus at time zero
	initial begin
		{sfr_wr, sfr_rd, xw_req, cr_req, dbg_req} = '0;
		{sfr_addr, sfr_wdata, xw_addr, xw_data, cr_addr, dbg_addr, dbg_wdata} = '0;
		dbg_op = OP_READ;
	end

	// register access; read data holds after the strobe, so sample late
	task automatic reg_acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_wr    <= !rd;
		sfr_rd    <= rd;
		sfr_addr  <= a;
		sfr_wdata <= d;
		@(posedge clk_sys);
		sfr_wr    <= 1'b0;
		sfr_rd    <= 1'b0;
		sfr_wdata <= ~d; // released data does not keep its value
		@(posedge clk_sys);
	endtask

	// always the full 16-bit move form, never the short-address one
	task automatic move(input logic [15:0] a, input logic [7:0] d, output int n);
		@(posedge clk_sys);
		xw_req  <= 1'b1;
		xw_addr <= a;
		xw_data <= d;
		@(posedge clk_sys);
		xw_req  <= 1'b0;
		xw_data <= ~d;
		n = 0;
		#1;
		while (cpu_stall === 1'b1 && n < 6000) begin
			@(posedge clk_sys) #1;
			n++;
		end
	endtask

	// code read; the valid pulse stands one cycle only
	task automatic code_rd(input logic [15:0] a, output logic v, output logic [7:0] q);
		@(posedge clk_sys);
		cr_req  <= 1'b1;
		cr_addr <= a;
		@(posedge clk_sys);
		cr_req  <= 1'b0;
		cr_addr <= ~a;
		#1;
		v = cr_valid;
		q = (cr_valid === 1'b1) ? cr_data : 8'hxx; // no valid pulse, no data
	endtask

	// debug request, waited out under a bound long enough for a full erase
	task automatic dbg(input fweg_op_e op, input logic [15:0] a, input logic [7:0] d,
		output logic rf, output logic [7:0] q);
		int i;
		@(posedge clk_sys);
		dbg_req   <= 1'b1;
		dbg_op    <= op;
		dbg_addr  <= a;
		dbg_wdata <= d;
		@(posedge clk_sys);
		dbg_req   <= 1'b0;
		dbg_wdata <= ~d;
		i = 0;
		#1;
		while (dbg_ack !== 1'b1 && i < 9000) begin
			@(posedge clk_sys) #1;
			i++;
		end
		// a missing acknowledge leaves unknowns that every compare rejects
		rf = (dbg_ack === 1'b1) ? dbg_refused : 1'bx;
		q  = (dbg_ack === 1'b1) ? dbg_rdata : 8'hxx;
	endtask
endmodule

// ---- tb/flash_write_erase_guard_tb_top.sv ----
`timescale 1ns/1ps
module flash_write_erase_guard_tb_top import fweg_pkg::*;;
	logic        clk_sys   = 1'b0;
	logic        srst      = 1'b1;
	logic        power_on  = 1'b1;
	logic [15:0] exec_addr = 16'h0000;
	logic        sfr_wr, sfr_rd, xw_req, cr_req, dbg_req, xw_to_flash, cr_valid, cpu_stall;
	logic        dbg_ack, dbg_refused, flash_err_rst, supply_mon_en, supply_rst_en;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xw_data, cr_data, dbg_wdata, dbg_rdata;
	logic [15:0] xw_addr, cr_addr, dbg_addr;
	fweg_op_e    dbg_op;
	int          n_errors    = 0;
	int          comparisons = 0;
	int          n;
	logic [7:0]  q;
	logic        f;

	// 200 MHz system clock
	initial forever #2.5 clk_sys = ~clk_sys;

	// short erase count keeps the run brief
	localparam int unsigned ERASE_SIM = 8;
	fweg_guard #(.ERASE_N(ERASE_SIM)) uut (
		.clk_sys, .srst, .power_on, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata,
		.xw_req, .xw_addr, .xw_data, .xw_to_flash, .exec_addr, .cr_req, .cr_addr,
		.cr_valid, .cr_data, .cpu_stall, .dbg_req, .dbg_op, .dbg_addr, .dbg_wdata,
		.dbg_ack, .dbg_refused, .dbg_rdata, .flash_err_rst, .supply_mon_en, .supply_rst_en
	);
	fweg_cpu_model cpu (
		.clk_sys, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .xw_req, .xw_addr, .xw_data,
		.cr_req, .cr_addr, .dbg_req, .dbg_op, .dbg_addr, .dbg_wdata, .cpu_stall,
		.cr_valid, .cr_data, .dbg_ack, .dbg_refused, .dbg_rdata
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chkf(input logic got, input logic exp, input string what);
		chk({7'h0, got}, {7'h0, exp}, what);
	endtask
	task automatic rst(input logic por);
		@(posedge clk_sys);
		srst     <= 1'b1;
		power_on <= por;
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	// masked register read into q
	task automatic rd(input logic [7:0] a, input logic [7:0] m);
		cpu.reg_acc(1'b1, a, 8'h00);
		q = sfr_rdata & m;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cpu.reg_acc(1'b0, a, d);
	endtask
	// gap between the codes on purpose: any delay is legal
	task automatic key();
		wr(KEY_OFS, KEY_FIRST);
		repeat (7) @(posedge clk_sys);
		wr(KEY_OFS, KEY_SECOND);
	endtask

	task automatic t_regs();
		rd(PSC_OFS, 8'hff);
		chk(q, PSC_RST, "psc reset");
		rd(PID_OFS, 8'hff);
		chk(q, PID_RST, "id reset");
		wr(PID_OFS, 8'h5a);
		rd(PID_OFS, 8'hff);
		chk(q, 8'h5a, "id rw");
		rd(8'h10, 8'hff);
		chk(q, 8'h00, "unmapped");
		chkf(supply_mon_en & supply_rst_en, 1'b1, "supply on");
	endtask

	task automatic t_write();
		wr(PSC_OFS, 8'h01);
		chkf(xw_to_flash, 1'b1, "to flash");
		key();
		rd(KEY_OFS, 8'h07);
		chk(q, 8'h02, "key open");
		cpu.move(16'h0100, 8'h5a, n);
		chkf(n == WRITE_CYC + 1, 1'b1, "write stall");
		rd(KEY_OFS, 8'h07);
		chk(q, 8'h00, "relock");
		rd(PSC_OFS, 8'h01);
		chk(q, 8'h01, "we kept");
		key();
		cpu.move(16'h0100, 8'hf0, n);
		cpu.code_rd(16'h0100, f, q);
		chk(q, 8'h50, "and only");
		// scratchpad select: same offset, separate bytes
		wr(PSC_OFS, 8'h05);
		key();
		cpu.move(16'h0100, 8'h33, n);
		cpu.code_rd(16'h0100, f, q);
		chk(q, 8'h33, "scratch write");
		wr(PSC_OFS, 8'h01);
		cpu.code_rd(16'h0100, f, q);
		chk(q, 8'h50, "user kept");
	endtask

	task automatic t_erase();
		wr(PSC_OFS, 8'h03);
		key();
		cpu.move(16'h01c3, 8'h00, n);
		chkf(n == ERASE_SIM + 512, 1'b1, "erase stall");
		cpu.code_rd(16'h0100, f, q);
		chk(q, ERASED, "page erased");
		wr(PSC_OFS, 8'h00);
	endtask

	task automatic t_keys();
		wr(PSC_OFS, 8'h01);
		cpu.move(16'h0300, 8'h00, n);
		rd(KEY_OFS, 8'h07);
		chk(q, 8'h04, "no key");
		key();
		rd(KEY_OFS, 8'h07);
		chk(q, 8'h04, "stays dead");
		rst(1'b1);
		rd(KEY_OFS, 8'h07);
		chk(q, 8'h00, "reset relock");
		wr(KEY_OFS, KEY_SECOND);
		rd(KEY_OFS, 8'h04);
		chk(q, 8'h04, "out of order");
		rst(1'b1);
	endtask

	task automatic t_supply();
		wr(SMON_OFS, 8'h00);
		wr(PSC_OFS, 8'h01);
		key();
		cpu.move(16'h0200, 8'h00, n);
		chkf(flash_err_rst, 1'b1, "supply off");
		rst(1'b0);
		rd(RSRC_OFS, 8'h40);
		chk(q, 8'h40, "error flag");
		cpu.code_rd(16'h0200, f, q);
		chk(q, ERASED, "untouched");
		rst(1'b1);
	endtask

	task automatic t_locks();
		cpu.dbg(OP_READ, 16'h2000, 8'h00, f, q);
		chkf(f, 1'b1, "dbg reserved");
		chkf(flash_err_rst, 1'b0, "dbg quiet");
		cpu.dbg(OP_WRITE, LOCK_ADDR, 8'hfe, f, q);
		exec_addr <= 16'h0400;
		cpu.code_rd(16'h0000, f, q);
		chkf(f, 1'b1, "lock deferred");
		rst(1'b1);
		cpu.code_rd(16'h0200, f, q);
		chkf(f, 1'b1, "one page");
		cpu.code_rd(16'h0000, f, q);
		chkf(flash_err_rst, 1'b1, "locked read");
		rst(1'b1);
		cpu.code_rd(16'h1e00, f, q);
		chkf(flash_err_rst, 1'b1, "lock page");
		rst(1'b1);
		exec_addr <= 16'h0000;
		cpu.code_rd(16'h0000, f, q);
		chk(q, ERASED, "locked code");
		cpu.dbg(OP_READ, 16'h0000, 8'h00, f, q);
		chkf(f, 1'b1, "dbg locked");
		wr(PSC_OFS, 8'h01);
		key();
		cpu.move(LOCK_ADDR, 8'hfc, n);
		chkf(flash_err_rst, 1'b1, "lock change");
		rst(1'b1);
		cpu.dbg(OP_FULL, 16'h0000, 8'h00, f, q);
		chkf(f, 1'b0, "full erase");
		rst(1'b1);
		cpu.dbg(OP_READ, LOCK_ADDR, 8'h00, f, q);
		chk(q, ERASED, "lock cleared");
	endtask

	task automatic results();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// main sequence
	initial begin
		rst(1'b1);
		t_regs();
		t_write();
		t_erase();
		t_keys();
		t_supply();
		t_locks();
		results();
	end

	// hang guard, about twice the expected run of some 38k cycles
	initial begin
		#400_000;
		n_errors++;
		results();
	end
endmodule
